/* rtcd_pkg.sv */
// package of constants for the rtc countdown timer control block
//
// Behaviour
// - raw status bits 0 clockwatch, 1 countdown show unmasked state, reset zero
// - masked status bits 0 and 1 are raw and enable; they drive irq outputs
// - clear register bit 0 written one clears clockwatch flag; zero no effect
// - clear register bit 1 written one clears countdown flag; zero no effect
// - single shot zero: interrupt at zero, then reload from load value
// - single shot one: interrupt at zero, then stop counting
// - run bit cleared halts the counter on the next slow tick
// - run bit set starts counting on the next slow tick; reads back
// - halted counter keeps its value, not cleared or reloaded except by a first load register write
// - load register write while halted sets the run bit
// - one-shot mode: hardware clears run bit when counter reaches zero
// - self-start bit 2: load or pattern write sets the run bit
// - pattern width field bits 10:4 sets pattern bits the pointer walks
// - clock source bit 11: zero raw slow clock, one trimmed clock
// - bit 12 zero gates timer clock while the run bit is clear, one keeps it running
// - mask register holds one enable per interrupt; one lets flag through
// - 32-bit first load register, reset zero, start and reload value
// - 128-bit pattern in four words, top word holds bits 127:96
package rtcd_pkg;
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h1c;
    localparam logic [7:0] ADDR_RAW_STATUS = 8'h20;
    localparam logic [7:0] ADDR_MASKED_STATUS = 8'h24;
    localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h28;
    localparam logic [7:0] ADDR_LOAD_READBACK = 8'h2c;
    localparam logic [7:0] ADDR_CONTROL = 8'h30;
    localparam logic [7:0] ADDR_RELOAD_1 = 8'h34;
    localparam logic [7:0] ADDR_RELOAD_2 = 8'h38;
    localparam logic [7:0] ADDR_PATTERN_1 = 8'h3c;
    localparam logic [7:0] ADDR_PATTERN_2 = 8'h40;
    localparam logic [7:0] ADDR_PATTERN_3 = 8'h44;
    localparam logic [7:0] ADDR_PATTERN_4 = 8'h48;
    localparam logic [7:0] ADDR_COUNT = 8'h4c;
    localparam int BIT_CLOCKWATCH = 0;
    localparam int BIT_COUNTDOWN = 1;
    localparam int CTL_SINGLE_SHOT = 0;
    localparam int CTL_RUN = 1;
    localparam int CTL_SELF_START = 2;
    localparam int CTL_WIDTH_LO = 4;
    localparam int CTL_WIDTH_HI = 10;
    localparam int CTL_CLK_SEL = 11;
    localparam int CTL_NO_GATE = 12;
    localparam logic [12:0] CTL_WMASK = 13'h1ff7;
    localparam logic [31:0] LOAD_RESET = 32'h00000000;
    localparam logic [31:0] READBACK_RESET = 32'h0fffffff;
    localparam logic [12:0] CONTROL_RESET = 13'h0000;
endpackage

/* rtcd_ctrl.sv */
// rtc countdown timer with interrupt status, mask, clear and control
`timescale 1ns/1ps
module rtcd_ctrl
    import rtcd_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [31:0] rdata,
    input wire logic slow_32k_clock,
    input wire logic trimmed_clock,
    input wire logic clockwatch_event,
    output logic clockwatch_irq,
    output logic countdown_irq,
    output logic irq,
    output logic timer_clk_enable,
    output logic [6:0] pattern_pointer,
    output logic pattern_bit
);
    import rtcd_pkg::*;

    typedef struct packed {
        logic [1:0] slow_sync;
        logic [1:0] trim_sync;
        logic [1:0] cw_sync;
        logic slow_prev;
        logic trim_prev;
        logic cw_prev;
        logic [1:0] raw;
        logic [1:0] enable;
        logic [12:0] control;
        logic [31:0] load1;
        logic [31:0] load2;
        logic [127:0] pattern;
        logic [31:0] counter;
        logic [31:0] readback;
        logic [31:0] irq_count;
        logic [6:0] pointer;
        logic [31:0] rdata;
    } rtcd_state_t;

    rtcd_state_t state_r;
    rtcd_state_t state_nxt;

    logic tick;
    logic cw_rise;
    logic [1:0] masked;
    logic load_wr;
    logic pat_wr;
    logic halted;
    logic [6:0] width;

    assign masked = state_r.raw & state_r.enable;
    assign clockwatch_irq = masked[BIT_CLOCKWATCH];
    assign countdown_irq = masked[BIT_COUNTDOWN];
    assign irq = |masked;
    assign rdata = state_r.rdata;
    assign pattern_pointer = state_r.pointer;
    assign pattern_bit = state_r.pattern[state_r.pointer];
    assign width = state_r.control[CTL_WIDTH_HI:CTL_WIDTH_LO];
    assign halted = !state_r.control[CTL_RUN];
    // ungated while running, or always when gating is switched off
    assign timer_clk_enable = state_r.control[CTL_NO_GATE] |
        state_r.control[CTL_RUN];

    always_comb begin
        state_nxt = state_r;
        state_nxt.slow_sync = {state_r.slow_sync[0], slow_32k_clock};
        state_nxt.trim_sync = {state_r.trim_sync[0], trimmed_clock};
        state_nxt.cw_sync = {state_r.cw_sync[0], clockwatch_event};
        state_nxt.slow_prev = state_r.slow_sync[1];
        state_nxt.trim_prev = state_r.trim_sync[1];
        state_nxt.cw_prev = state_r.cw_sync[1];
        // timer clock source select
        if (state_r.control[CTL_CLK_SEL]) begin
            tick = state_r.trim_sync[1] & !state_r.trim_prev;
        end else begin
            tick = state_r.slow_sync[1] & !state_r.slow_prev;
        end
        cw_rise = state_r.cw_sync[1] & !state_r.cw_prev;
        load_wr = wr_stb && (addr == ADDR_RELOAD_1 || addr == ADDR_RELOAD_2);
        pat_wr = wr_stb && addr >= ADDR_PATTERN_1 && addr <= ADDR_PATTERN_4;

        // counting on the selected tick; halted counter stays frozen
        if (tick && state_r.control[CTL_RUN]) begin
            if (state_r.counter == 32'h0) begin
                state_nxt.irq_count = state_r.irq_count + 32'h1;
                if (state_r.control[CTL_SINGLE_SHOT]) begin
                    state_nxt.control[CTL_RUN] = 1'b0;
                end else begin
                    state_nxt.counter = state_r.load1;
                end
                if (state_r.pointer >= width) begin
                    state_nxt.pointer = 7'h00;
                end else begin
                    state_nxt.pointer = state_r.pointer + 7'h01;
                end
            end else begin
                state_nxt.counter = state_r.counter - 32'h1;
            end
        end

        // register writes
        if (wr_stb) begin
            unique case (addr)
                ADDR_IRQ_ENABLE: state_nxt.enable = wdata[1:0];
                ADDR_IRQ_CLEAR: begin
                    if (wdata[BIT_CLOCKWATCH]) begin
                        state_nxt.raw[BIT_CLOCKWATCH] = 1'b0;
                    end
                    if (wdata[BIT_COUNTDOWN]) begin
                        state_nxt.raw[BIT_COUNTDOWN] = 1'b0;
                    end
                end
                ADDR_CONTROL: begin
                    state_nxt.control = wdata[12:0] & CTL_WMASK;
                end
                ADDR_RELOAD_1: begin
                    state_nxt.load1 = wdata;
                    state_nxt.readback = wdata;
                    if (halted) begin
                        state_nxt.counter = wdata;
                        state_nxt.pointer = 7'h00;
                    end
                end
                ADDR_RELOAD_2: state_nxt.load2 = wdata;
                ADDR_PATTERN_1: state_nxt.pattern[31:0] = wdata;
                ADDR_PATTERN_2: state_nxt.pattern[63:32] = wdata;
                ADDR_PATTERN_3: state_nxt.pattern[95:64] = wdata;
                ADDR_PATTERN_4: state_nxt.pattern[127:96] = wdata;
                default: ;
            endcase
        end
        if (load_wr && halted) begin
            state_nxt.control[CTL_RUN] = 1'b1;
        end
        if ((load_wr || pat_wr) && state_r.control[CTL_SELF_START]) begin
            state_nxt.control[CTL_RUN] = 1'b1;
        end

        // events set sticky flags after clears so a same-cycle set wins
        if (cw_rise) begin
            state_nxt.raw[BIT_CLOCKWATCH] = 1'b1;
        end
        if (tick && state_r.control[CTL_RUN] && state_r.counter == 32'h0)
        begin
            state_nxt.raw[BIT_COUNTDOWN] = 1'b1;
        end

        // read data, valid the cycle after the strobe
        state_nxt.rdata = 32'h0;
        if (rd_stb) begin
            unique case (addr)
                ADDR_IRQ_ENABLE: state_nxt.rdata = {30'h0, state_r.enable};
                ADDR_RAW_STATUS: state_nxt.rdata = {30'h0, state_r.raw};
                ADDR_MASKED_STATUS: state_nxt.rdata = {30'h0, masked};
                ADDR_LOAD_READBACK: state_nxt.rdata = state_r.readback;
                ADDR_CONTROL: state_nxt.rdata = {19'h0, state_r.control};
                ADDR_RELOAD_1: state_nxt.rdata = state_r.load1;
                ADDR_RELOAD_2: state_nxt.rdata = state_r.load2;
                ADDR_PATTERN_1: state_nxt.rdata = state_r.pattern[31:0];
                ADDR_PATTERN_2: state_nxt.rdata = state_r.pattern[63:32];
                ADDR_PATTERN_3: state_nxt.rdata = state_r.pattern[95:64];
                ADDR_PATTERN_4: state_nxt.rdata = state_r.pattern[127:96];
                ADDR_COUNT: state_nxt.rdata = state_r.irq_count;
                default: state_nxt.rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_r <= '0;
            state_r.control <= CONTROL_RESET;
            state_r.load1 <= LOAD_RESET;
            state_r.readback <= READBACK_RESET;
        end else begin
            state_r <= state_nxt;
        end
    end
endmodule

/* rtcd_ctrl_assertions.sv */
// port-level assertions for the rtc countdown timer block
`timescale 1ns/1ps
module rtcd_ctrl_assertions
    import rtcd_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_stb,
    input wire logic slow_32k_clock,
    input wire logic clockwatch_event,
    input wire logic clockwatch_irq,
    input wire logic countdown_irq,
    input wire logic irq,
    input wire logic timer_clk_enable
);
    logic clr;
    logic cm;
    logic ctl;
    assign clr = wr_stb && addr == ADDR_IRQ_CLEAR;
    assign cm = clr || (wr_stb && addr == ADDR_IRQ_ENABLE);
    assign ctl = wr_stb && addr == ADDR_CONTROL;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    a_irq_or: assert property (irq == (clockwatch_irq | countdown_irq))
        else $error("irq is not the or of masked flags");
    a_cw_clear: assert property (clr && wdata[0] &&
        clockwatch_event == $past(clockwatch_event, 4) |=> !clockwatch_irq)
        else $error("clockwatch flag not cleared");
    a_cd_clear: assert property (clr && wdata[1] &&
        slow_32k_clock == $past(slow_32k_clock, 4) |=> !countdown_irq)
        else $error("countdown flag not cleared");
    a_cd_hold: assert property (countdown_irq && !cm |=> countdown_irq)
        else $error("countdown flag dropped without clear");
    a_cw_hold: assert property (clockwatch_irq && !cm |=> clockwatch_irq)
        else $error("clockwatch flag dropped without clear");
    a_gate_on: assert property (ctl && wdata[12] |=> timer_clk_enable)
        else $error("clock not forced on");
    a_gate_off: assert property (ctl && !wdata[12] && !wdata[1]
        |=> !timer_clk_enable)
        else $error("clock not gated");
    a_load_run: assert property (wr_stb && addr == ADDR_RELOAD_1
        && !timer_clk_enable |=> timer_clk_enable)
        else $error("load while halted did not start");
    cover property ($rose(countdown_irq));
    cover property ($rose(clockwatch_irq));
    cover property ($fell(timer_clk_enable));
endmodule

/* rtcd_ctrl_bench.sv */
// self-checking bench for the rtc countdown timer block
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
    $display("[ERR] %s exp %h got %h", n, e, g); end end
module rtcd_ctrl_bench;
    import rtcd_pkg::*;
    logic clk = 0, reset = 1, wr_stb = 0, rd_stb = 0, rd_d = 0, sel = 0;
    logic slow_32k_clock = 0, trimmed_clock = 0, clockwatch_event = 0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0, rnd = 32'hd2231847, rdata, ev;
    logic clockwatch_irq, countdown_irq, irq, timer_clk_enable, pattern_bit;
    logic [6:0] pattern_pointer;
    logic [31:0] exp_q[$];
    // output notes: each toggle of out_tg asks for one compare of outs
    logic out_tg = 0, out_seen = 0;
    logic [11:0] out_q[$], eo, outs;
    int n_fail = 0, tests_run = 0, cyc = 0, ld;
    rtcd_ctrl dut_u (.clk, .reset, .addr, .wdata, .wr_stb, .rd_stb, .rdata,
        .slow_32k_clock, .trimmed_clock, .clockwatch_event, .clockwatch_irq,
        .countdown_irq, .irq, .timer_clk_enable, .pattern_pointer,
        .pattern_bit);
    assign outs = {clockwatch_irq, countdown_irq, irq, timer_clk_enable,
        pattern_pointer, pattern_bit};
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    task give_verdict();
        $display("checks %0d errors %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task bus(input logic w, r, input logic [7:0] a, input logic [31:0] d);
        wr_stb <= w;
        rd_stb <= r;
        addr <= a;
        wdata <= d;
        @(posedge clk);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, 1'b0, a, d);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, 1'b1, a, 32'h0);
    endtask
    // note the expected outputs; they are compared at the next edge
    task look(input logic [11:0] e);
        out_q.push_back(e);
        out_tg <= ~out_tg;
        bus(1'b0, 1'b0, 8'h00, 32'h0);
    endtask
    // slow ticks on the selected timer clock, strobes idle
    task tick(input int n);
        bus(1'b0, 1'b0, 8'h00, 32'h0);
        repeat (n) begin
            if (sel) trimmed_clock <= 1; else slow_32k_clock <= 1;
            repeat (4) @(posedge clk);
            trimmed_clock <= 0;
            slow_32k_clock <= 0;
            repeat (4) @(posedge clk);
        end
    endtask
    initial begin
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            give_verdict();
        end
    end
    // read data stand only in the cycle after the strobe
    always @(posedge clk) begin
        if (rd_d) begin
            ev = exp_q.pop_front();
            `CHK("rdata", ev, rdata)
        end
        rd_d <= rd_stb;
        if (out_tg != out_seen) begin
            eo = out_q.pop_front();
            `CHK("outputs", eo, outs)
        end
        out_seen <= out_tg;
    end
    initial begin
        repeat (3) @(posedge clk);
        reset <= 0;
        rd(ADDR_RAW_STATUS, 0);
        rd(ADDR_MASKED_STATUS, 0);
        rd(ADDR_LOAD_READBACK, READBACK_RESET);
        rd(ADDR_RELOAD_1, LOAD_RESET);
        rd(ADDR_CONTROL, 0);
        rd(8'hf0, 0);
        wr(ADDR_IRQ_ENABLE, 32'h3);
        clockwatch_event <= 1;
        tick(1);
        clockwatch_event <= 0;
        rd(ADDR_MASKED_STATUS, 1);
        look({4'b1010, 7'h00, 1'b0});
        wr(ADDR_IRQ_CLEAR, 2);
        rd(ADDR_RAW_STATUS, 1);
        wr(ADDR_IRQ_CLEAR, 1);
        rd(ADDR_RAW_STATUS, 0);
        rnd = xs(rnd);
        ld = 2 + int'(rnd[1:0]);
        wr(ADDR_RELOAD_1, 32'(ld));
        rd(ADDR_CONTROL, 2);
        rd(ADDR_LOAD_READBACK, 32'(ld));
        tick(ld);
        rd(ADDR_RAW_STATUS, 0);
        tick(1);
        rd(ADDR_MASKED_STATUS, 2);
        look({4'b0111, 7'h00, 1'b0});
        wr(ADDR_IRQ_CLEAR, 1);
        rd(ADDR_RAW_STATUS, 2);
        tick(ld + 1);
        rd(ADDR_COUNT, 2);
        wr(ADDR_CONTROL, 32'h1000);
        wr(ADDR_IRQ_CLEAR, 2);
        look({4'b0001, 7'h00, 1'b0});
        rd(ADDR_RAW_STATUS, 0);
        tick(ld + 2);
        rd(ADDR_COUNT, 2);
        wr(ADDR_CONTROL, 2);
        tick(ld + 1);
        rd(ADDR_COUNT, 3);
        sel = 1;
        wr(ADDR_IRQ_CLEAR, 2);
        wr(ADDR_CONTROL, 32'h801);
        wr(ADDR_RELOAD_1, 32'(ld));
        tick(ld + 1);
        rd(ADDR_CONTROL, 32'h801);
        rd(ADDR_RAW_STATUS, 2);
        tick(ld + 2);
        rd(ADDR_COUNT, 4);
        rnd = xs(rnd);
        wr(ADDR_CONTROL, {19'h0, 1'b0, rnd[11:4], 4'hd});
        wr(ADDR_PATTERN_4, rnd);
        rd(ADDR_CONTROL, {19'h0, 1'b0, rnd[11:4], 4'h7});
        // pattern walk: width 2, zero load so every tick is a zero event
        sel = 0;
        wr(ADDR_CONTROL, 32'h20);
        wr(ADDR_PATTERN_1, 32'h6);
        rd(ADDR_PATTERN_1, 32'h6);
        rd(ADDR_PATTERN_4, rnd);
        wr(ADDR_RELOAD_1, 32'h0);
        tick(1);
        look({4'b0111, 7'h01, 1'b1});
        tick(2);
        look({4'b0111, 7'h00, 1'b0});
        rd(ADDR_COUNT, 7);
        bus(1'b0, 1'b0, 8'h00, 32'h0);
        repeat (3) @(posedge clk);
        give_verdict();
    end
endmodule
bind rtcd_ctrl rtcd_ctrl_assertions chk_u (.clk, .reset, .addr, .wdata,
    .wr_stb, .slow_32k_clock, .clockwatch_event, .clockwatch_irq,
    .countdown_irq, .irq, .timer_clk_enable);
